/* include/rtcsf_consts.svh */
// Constants of the real-time clock time, date and supply-flag block
`ifndef RTCSF_CONSTS_SVH
`define RTCSF_CONSTS_SVH

`define RTCSF_SYS_CLK_HZ 20000000
`define RTCSF_TICK_PERIOD_MS 1000
`define RTCSF_TICK_CYCLES (`RTCSF_TICK_PERIOD_MS * (`RTCSF_SYS_CLK_HZ / 1000))
// Arbitrary slave address
`define RTCSF_DEV_ADDR 7'h2A

`define RTCSF_ADDR_CTRL_A 8'h00
`define RTCSF_ADDR_CTRL_B 8'h01
`define RTCSF_ADDR_CTRL_C 8'h02
`define RTCSF_ADDR_SECONDS 8'h03
`define RTCSF_ADDR_MINUTES 8'h04
`define RTCSF_ADDR_HOURS 8'h05
`define RTCSF_ADDR_DAYS 8'h06
`define RTCSF_ADDR_WEEKDAYS 8'h07

`define RTCSF_BIT_OSC_STOP 7
`define RTCSF_BIT_MERIDIEM 5
`define RTCSF_BIT_HOUR_12 3
`define RTCSF_BIT_SWITCH_IE 1
`define RTCSF_BIT_CELL_LOW_IE 0
`define RTCSF_PM_MSB 7
`define RTCSF_PM_LSB 5
`define RTCSF_BIT_SUPPLY_SW 3
`define RTCSF_BIT_CELL_LOW 2

`define RTCSF_RST_PM 3'h7
`define RTCSF_RST_SECONDS 7'h00
`define RTCSF_RST_MINUTES 7'h00
`define RTCSF_RST_HOURS 6'h00
`define RTCSF_RST_DAYS 6'h01
`define RTCSF_RST_WEEKDAYS 3'h0

`define RTCSF_SEC_LAST 8'h59
`define RTCSF_H24_LAST 8'h23
`define RTCSF_H12_LAST 8'h12
`define RTCSF_H12_PM_EDGE 5'h11
`define RTCSF_WDAY_LAST 3'h6

`endif

/* include/rtcsf_pkg.sv */
// Types shared by the real-time clock block
package rtcsf_pkg;
	typedef enum logic [2:0] {
		RTCSF_ST_IDLE = 3'b000,
		RTCSF_ST_ADDR = 3'b001,
		RTCSF_ST_PTR = 3'b010,
		RTCSF_ST_WDATA = 3'b011,
		RTCSF_ST_ACK = 3'b100,
		RTCSF_ST_RDATA = 3'b101,
		RTCSF_ST_MACK = 3'b110
	} rtcsf_i2c_state_type;

	typedef enum logic [1:0] {
		RTCSF_SW_OFF = 2'b00,
		RTCSF_SW_STANDARD = 2'b01,
		RTCSF_SW_DIRECT = 2'b10
	} rtcsf_switch_mode_type;
endpackage

/* rtl/rtcsf_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module rtcsf_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;

	initial begin
		if (WIDTH < 1) $error("rtcsf_sync: WIDTH must be at least 1");
	end

	// A bit changes only once stages two and three agree
	assign level_next = (s2_reg & s3_reg) | (level_reg & (s2_reg | s3_reg));
	assign level_out = level_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			level_reg <= INIT;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end
endmodule

/* rtl/rtcsf_bcd_step.sv */
// Two-digit BCD increment with wrap from a last value to a first value
`timescale 1ns/1ps
module rtcsf_bcd_step (
	input wire logic [7:0] cur,
	input wire logic [7:0] last,
	input wire logic [7:0] first,
	output logic [7:0] nxt,
	output logic wrap
);
	logic unit_nine;
	logic [7:0] inc_val;

	assign unit_nine = (cur[3:0] == 4'h9);
	assign inc_val = unit_nine ? {4'(cur[7:4] + 4'h1), 4'h0} : {cur[7:4], 4'(cur[3:0] + 4'h1)};
	assign wrap = (cur == last);
	assign nxt = wrap ? first : inc_val;
endmodule

/* rtl/rtcsf_top.sv */
// Time and date counters, supply flags and serial register access
`timescale 1ns/1ps
`include "rtcsf_consts.svh"
module rtcsf_top
	import rtcsf_pkg::*;
#(
	parameter int TICK_CYCLES = `RTCSF_TICK_CYCLES,
	parameter logic [6:0] DEV_ADDR = `RTCSF_DEV_ADDR
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic osc_stopped,
	input wire logic vdd_below_bat,
	input wire logic vdd_below_thr,
	input wire logic bat_below_low,
	input wire logic bat_replaced,
	input wire logic [7:0] month_bcd,
	input wire logic [7:0] year_bcd,
	output logic on_backup,
	output logic month_carry,
	output logic primary_irq_out_n
);
	localparam int DIV_W = $clog2(TICK_CYCLES + 1);

	initial begin
		if (TICK_CYCLES < 2) $error("rtcsf_top: TICK_CYCLES must be at least 2");
	end

	// Pin and analog inputs, three stages each
	logic scl_s;
	logic sda_s;
	logic osc_stop_s;
	logic below_bat_s;
	logic below_thr_s;
	logic low_cell_s;
	logic replaced_s;

	rtcsf_sync #(.WIDTH(2), .INIT(2'b11)) u_sync_bus (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in({scl_in, sda_in}),
		.level_out({scl_s, sda_s})
	);

	rtcsf_sync #(.WIDTH(5), .INIT(5'h10)) u_sync_ana (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in({osc_stopped, vdd_below_bat, vdd_below_thr, bat_below_low, bat_replaced}),
		.level_out({osc_stop_s, below_bat_s, below_thr_s, low_cell_s, replaced_s})
	);

	// Registers
	logic osc_stop_flag_reg;
	logic [6:0] sec_reg;
	logic [6:0] min_reg;
	logic [5:0] hour_reg;
	logic [5:0] day_reg;
	logic [2:0] wday_reg;
	logic hour_12_reg;
	logic switch_irq_enable_reg;
	logic cell_low_irq_enable_reg;
	logic [2:0] power_mgmt_select_reg;
	logic supply_switched_flag_reg;
	logic cell_low_flag_reg;
	logic on_backup_reg;
	logic month_carry_reg;
	logic irq_n_reg;
	logic [DIV_W-1:0] div_reg;
	logic tick_pend_reg;

	// Serial slave state
	rtcsf_i2c_state_type st_reg;
	rtcsf_i2c_state_type after_ack_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	logic [7:0] shift_reg;
	logic [3:0] cnt_reg;
	logic [7:0] ptr_reg;
	logic sda_oe_reg;
	logic nack_reg;

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_done;
	logic wr_stb;
	logic rd_load;
	logic [7:0] rdata;
	logic busy;

	assign scl_rise = scl_s && !scl_d_reg;
	assign scl_fall = !scl_s && scl_d_reg;
	// Interface is deaf while running from backup
	assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s && !on_backup_reg;
	assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;
	assign byte_done = scl_fall && (cnt_reg == 4'h8);
	assign wr_stb = byte_done && (st_reg == RTCSF_ST_WDATA);
	assign rd_load = scl_fall && (((st_reg == RTCSF_ST_ACK) && (after_ack_reg == RTCSF_ST_RDATA))
		|| ((st_reg == RTCSF_ST_MACK) && !nack_reg));
	assign busy = (st_reg != RTCSF_ST_IDLE);

	// Read multiplexer
	assign rdata = (ptr_reg == `RTCSF_ADDR_CTRL_A) ? {4'h0, hour_12_reg, 3'h0} :
		(ptr_reg == `RTCSF_ADDR_CTRL_B) ? {6'h00, switch_irq_enable_reg, cell_low_irq_enable_reg} :
		(ptr_reg == `RTCSF_ADDR_CTRL_C) ? {power_mgmt_select_reg, 1'b0,
			supply_switched_flag_reg, cell_low_flag_reg, 2'h0} :
		(ptr_reg == `RTCSF_ADDR_SECONDS) ? {osc_stop_flag_reg, sec_reg} :
		(ptr_reg == `RTCSF_ADDR_MINUTES) ? {1'b0, min_reg} :
		(ptr_reg == `RTCSF_ADDR_HOURS) ? {2'h0, hour_reg} :
		(ptr_reg == `RTCSF_ADDR_DAYS) ? {2'h0, day_reg} :
		(ptr_reg == `RTCSF_ADDR_WEEKDAYS) ? {5'h00, wday_reg} : 8'h00;

	// Serial slave: shift on SCL rise, act on SCL fall
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= RTCSF_ST_IDLE;
			after_ack_reg <= RTCSF_ST_IDLE;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			shift_reg <= 8'h00;
			cnt_reg <= 4'h0;
			ptr_reg <= 8'h00;
			sda_oe_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			if (stop_cond || (on_backup_reg && busy)) begin
				st_reg <= RTCSF_ST_IDLE;
				sda_oe_reg <= 1'b0;
			end else if (start_cond) begin
				st_reg <= RTCSF_ST_ADDR;
				cnt_reg <= 4'h0;
				sda_oe_reg <= 1'b0;
			end else if (scl_rise) begin
				if (st_reg == RTCSF_ST_MACK) begin
					nack_reg <= sda_s;
				end else if (st_reg != RTCSF_ST_RDATA && st_reg != RTCSF_ST_ACK) begin
					shift_reg <= {shift_reg[6:0], sda_s};
					cnt_reg <= 4'(cnt_reg + 4'h1);
				end
			end else if (rd_load) begin
				shift_reg <= rdata;
				ptr_reg <= 8'(ptr_reg + 8'h01);
				sda_oe_reg <= !rdata[7];
				cnt_reg <= 4'h1;
				st_reg <= RTCSF_ST_RDATA;
			end else if (scl_fall) begin
				case (st_reg)
					RTCSF_ST_ADDR: begin
						if (cnt_reg == 4'h8) begin
							if (shift_reg[7:1] == DEV_ADDR) begin
								sda_oe_reg <= 1'b1;
								st_reg <= RTCSF_ST_ACK;
								after_ack_reg <= shift_reg[0] ? RTCSF_ST_RDATA : RTCSF_ST_PTR;
							end else begin
								st_reg <= RTCSF_ST_IDLE;
							end
						end
					end
					RTCSF_ST_PTR, RTCSF_ST_WDATA: begin
						if (cnt_reg == 4'h8) begin
							if (st_reg == RTCSF_ST_PTR) begin
								ptr_reg <= shift_reg;
							end else begin
								ptr_reg <= 8'(ptr_reg + 8'h01);
							end
							sda_oe_reg <= 1'b1;
							st_reg <= RTCSF_ST_ACK;
							after_ack_reg <= RTCSF_ST_WDATA;
						end
					end
					RTCSF_ST_ACK: begin
						sda_oe_reg <= 1'b0;
						cnt_reg <= 4'h0;
						st_reg <= after_ack_reg;
					end
					RTCSF_ST_RDATA: begin
						if (cnt_reg == 4'h8) begin
							sda_oe_reg <= 1'b0;
							st_reg <= RTCSF_ST_MACK;
						end else begin
							sda_oe_reg <= !shift_reg[6];
							shift_reg <= {shift_reg[6:0], 1'b0};
							cnt_reg <= 4'(cnt_reg + 4'h1);
						end
					end
					RTCSF_ST_MACK: begin
						st_reg <= RTCSF_ST_IDLE;
					end
					default: begin
						st_reg <= RTCSF_ST_IDLE;
					end
				endcase
			end
		end
	end

	// One-second tick, held off while the oscillator is stopped
	logic tick;
	logic do_step;
	assign tick = (div_reg == DIV_W'(TICK_CYCLES - 1)) && !osc_stop_s;
	// Counting is blocked during access; one tick is kept pending
	assign do_step = (tick || tick_pend_reg) && !busy;

	// Calendar stepping
	logic [7:0] sec_nxt;
	logic [7:0] min_nxt;
	logic [7:0] h24_nxt;
	logic [7:0] h12_nxt;
	logic [7:0] day_nxt;
	logic [7:0] day_last;
	logic sec_wrap;
	logic min_wrap;
	logic h24_wrap;
	logic day_wrap;
	logic leap_year;
	logic hour_carry;
	logic pm_edge;

	rtcsf_bcd_step u_sec (
		.cur({1'b0, sec_reg}),
		.last(`RTCSF_SEC_LAST),
		.first(8'h00),
		.nxt(sec_nxt),
		.wrap(sec_wrap)
	);

	rtcsf_bcd_step u_min (
		.cur({1'b0, min_reg}),
		.last(`RTCSF_SEC_LAST),
		.first(8'h00),
		.nxt(min_nxt),
		.wrap(min_wrap)
	);

	rtcsf_bcd_step u_h24 (
		.cur({2'h0, hour_reg}),
		.last(`RTCSF_H24_LAST),
		.first(8'h00),
		.nxt(h24_nxt),
		.wrap(h24_wrap)
	);

	rtcsf_bcd_step u_h12 (
		.cur({3'h0, hour_reg[4:0]}),
		.last(`RTCSF_H12_LAST),
		.first(8'h01),
		.nxt(h12_nxt),
		.wrap()
	);

	rtcsf_bcd_step u_day (
		.cur({2'h0, day_reg}),
		.last(day_last),
		.first(8'h01),
		.nxt(day_nxt),
		.wrap(day_wrap)
	);

	// Year in BCD divisible by four, year 00 included
	assign leap_year = year_bcd[4] ? (year_bcd[3:0] == 4'h2 || year_bcd[3:0] == 4'h6)
		: (year_bcd[3:0] == 4'h0 || year_bcd[3:0] == 4'h4 || year_bcd[3:0] == 4'h8);
	assign day_last = (month_bcd == 8'h02) ? (leap_year ? 8'h29 : 8'h28) :
		(month_bcd == 8'h04 || month_bcd == 8'h06 || month_bcd == 8'h09
		|| month_bcd == 8'h11) ? 8'h30 : 8'h31;
	assign pm_edge = (hour_reg[4:0] == `RTCSF_H12_PM_EDGE);
	assign hour_carry = hour_12_reg ? (pm_edge && hour_reg[`RTCSF_BIT_MERIDIEM]) : h24_wrap;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= '0;
			tick_pend_reg <= 1'b0;
		end else begin
			div_reg <= (div_reg == DIV_W'(TICK_CYCLES - 1)) ? '0 : DIV_W'(div_reg + 1'b1);
			tick_pend_reg <= busy && (tick || tick_pend_reg);
		end
	end

	logic wr_ctrl_c;
	logic wr_sec;
	assign wr_ctrl_c = wr_stb && (ptr_reg == `RTCSF_ADDR_CTRL_C);
	assign wr_sec = wr_stb && (ptr_reg == `RTCSF_ADDR_SECONDS);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sec_reg <= `RTCSF_RST_SECONDS;
			min_reg <= `RTCSF_RST_MINUTES;
			hour_reg <= `RTCSF_RST_HOURS;
			day_reg <= `RTCSF_RST_DAYS;
			wday_reg <= `RTCSF_RST_WEEKDAYS;
			month_carry_reg <= 1'b0;
		end else begin
			month_carry_reg <= 1'b0;
			if (wr_stb) begin
				if (wr_sec) sec_reg <= shift_reg[6:0];
				if (ptr_reg == `RTCSF_ADDR_MINUTES) min_reg <= shift_reg[6:0];
				if (ptr_reg == `RTCSF_ADDR_HOURS) hour_reg <= shift_reg[5:0];
				if (ptr_reg == `RTCSF_ADDR_DAYS) day_reg <= shift_reg[5:0];
				if (ptr_reg == `RTCSF_ADDR_WEEKDAYS) wday_reg <= shift_reg[2:0];
			end else if (do_step) begin
				sec_reg <= sec_nxt[6:0];
				if (sec_wrap) begin
					min_reg <= min_nxt[6:0];
					if (min_wrap) begin
						if (hour_12_reg) begin
							hour_reg <= {hour_reg[5] ^ pm_edge, h12_nxt[4:0]};
						end else begin
							hour_reg <= h24_nxt[5:0];
						end
						if (hour_carry) begin
							day_reg <= day_nxt[5:0];
							wday_reg <= (wday_reg == `RTCSF_WDAY_LAST) ? 3'h0 : 3'(wday_reg + 3'h1);
							month_carry_reg <= day_wrap;
						end
					end
				end
			end
		end
	end

	// Supply mode decode
	rtcsf_switch_mode_type sw_mode;
	logic low_detect_en;
	logic backup_next;
	assign sw_mode = (power_mgmt_select_reg[1:0] == 2'b00) ? RTCSF_SW_STANDARD :
		(power_mgmt_select_reg[1:0] == 2'b01) ? RTCSF_SW_DIRECT : RTCSF_SW_OFF;
	assign low_detect_en = !power_mgmt_select_reg[2];
	assign backup_next = (sw_mode == RTCSF_SW_STANDARD) ? (below_bat_s && below_thr_s) :
		(sw_mode == RTCSF_SW_DIRECT) ? below_bat_s : 1'b0;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_stop_flag_reg <= 1'b1;
			hour_12_reg <= 1'b0;
			switch_irq_enable_reg <= 1'b0;
			cell_low_irq_enable_reg <= 1'b0;
			power_mgmt_select_reg <= `RTCSF_RST_PM;
			supply_switched_flag_reg <= 1'b0;
			cell_low_flag_reg <= 1'b0;
			on_backup_reg <= 1'b0;
			irq_n_reg <= 1'b1;
		end else begin
			// Set wins over clear; clear refused while stopped
			if (osc_stop_s) begin
				osc_stop_flag_reg <= 1'b1;
			end else if (wr_sec && !shift_reg[`RTCSF_BIT_OSC_STOP]) begin
				osc_stop_flag_reg <= 1'b0;
			end
			if (wr_stb && ptr_reg == `RTCSF_ADDR_CTRL_A) begin
				hour_12_reg <= shift_reg[`RTCSF_BIT_HOUR_12];
			end
			if (wr_stb && ptr_reg == `RTCSF_ADDR_CTRL_B) begin
				switch_irq_enable_reg <= shift_reg[`RTCSF_BIT_SWITCH_IE];
				cell_low_irq_enable_reg <= shift_reg[`RTCSF_BIT_CELL_LOW_IE];
			end
			if (wr_ctrl_c && shift_reg[`RTCSF_PM_MSB:`RTCSF_PM_LSB] != 3'b110) begin
				power_mgmt_select_reg <= shift_reg[`RTCSF_PM_MSB:`RTCSF_PM_LSB];
			end
			on_backup_reg <= backup_next;
			if (sw_mode == RTCSF_SW_OFF) begin
				supply_switched_flag_reg <= 1'b0;
			end else if (backup_next && !on_backup_reg) begin
				supply_switched_flag_reg <= 1'b1;
			end else if (wr_ctrl_c && !shift_reg[`RTCSF_BIT_SUPPLY_SW] && !on_backup_reg) begin
				supply_switched_flag_reg <= 1'b0;
			end
			// Host writes never reach this flag
			if (low_detect_en && low_cell_s) begin
				cell_low_flag_reg <= 1'b1;
			end else if (replaced_s) begin
				cell_low_flag_reg <= 1'b0;
			end
			irq_n_reg <= !((cell_low_irq_enable_reg && cell_low_flag_reg)
				|| (switch_irq_enable_reg && supply_switched_flag_reg));
		end
	end

	logic sda_out_reg;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
		end
	end

	assign sda_out = sda_out_reg;
	assign sda_oe = sda_oe_reg;
	assign on_backup = on_backup_reg;
	assign month_carry = month_carry_reg;
	assign primary_irq_out_n = irq_n_reg;
endmodule

/* test/rtcsf_monitor.sv */
// Port checker for the time, date and supply-flag block
`timescale 1ns/1ps
module rtcsf_monitor (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic vdd_below_bat,
	input wire logic vdd_below_thr,
	input wire logic bat_below_low,
	input wire logic on_backup,
	input wire logic month_carry,
	input wire logic primary_irq_out_n
);
	logic [3:0] cause_age;
	logic [1:0] fail_run;
	logic [1:0] ok_run;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Age of last interrupt cause, run lengths of supply conditions
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cause_age <= 4'hF;
			fail_run <= 2'h0;
			ok_run <= 2'h0;
		end else begin
			cause_age <= (on_backup || bat_below_low || sda_oe) ? 4'h0 :
				cause_age + 4'(cause_age != 4'hF);
			fail_run <= vdd_below_bat ? fail_run + 2'(fail_run != 2'h3) : 2'h0;
			ok_run <= (vdd_below_bat && vdd_below_thr) ? 2'h0 : ok_run + 2'(ok_run != 2'h3);
		end
	end
	sequence s_quiet;
		primary_irq_out_n && !sda_oe && !on_backup && !month_carry;
	endsequence
	sequence s_carry_done;
		!month_carry [*8];
	endsequence
	AST_RESET_QUIET: assert property ($rose(arst_n) |-> s_quiet)
		else $error("outputs not idle after reset");
	AST_CARRY_PULSE: assert property (month_carry |=> s_carry_done)
		else $error("day carry pulse repeated");
	AST_IRQ_CAUSE: assert property ($fell(primary_irq_out_n) |-> cause_age <= 4'h8)
		else $error("interrupt asserted without cause");
	AST_RISE_NEEDS_FAIL: assert property ($rose(on_backup) |-> fail_run >= 2'h2)
		else $error("backup selected without main below backup");
	AST_FALL_NEEDS_RETURN: assert property ($fell(on_backup) |-> ok_run >= 2'h2)
		else $error("backup left while main still failed");
	AST_STAY_ON_MAIN: assert property (!vdd_below_bat [*8] |-> !on_backup)
		else $error("backup held with main above backup");
	AST_DEAD_ON_BACKUP: assert property (on_backup [*8] |-> !sda_oe)
		else $error("serial pin driven on backup");
	AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_out)
		else $error("serial pin driven high");
endmodule
bind rtcsf_top rtcsf_monitor u_mon (
	.sys_clk(sys_clk), .arst_n(arst_n), .sda_out(sda_out), .sda_oe(sda_oe),
	.vdd_below_bat(vdd_below_bat), .vdd_below_thr(vdd_below_thr),
	.bat_below_low(bat_below_low), .on_backup(on_backup), .month_carry(month_carry),
	.primary_irq_out_n(primary_irq_out_n)
);

/* test/rtcsf_i2c_host.sv */
// Behavioural two-wire bus host on the serial pins
`timescale 1ns/1ps
module rtcsf_i2c_host (
	input wire logic sys_clk,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// 400 ns bit clock: six cycles low, two high
	// Data changes only after the device has released its acknowledge
	task automatic bitx(input logic b, output logic s);
		scl = 1'b0;
		hold(5);
		sda_drv = b;
		hold(1);
		scl = 1'b1;
		hold(2);
		s = sda_wire;
	endtask
	task automatic start(input logic rep);
		if (rep) begin
			scl = 1'b0;
			hold(6);
			sda_drv = 1'b1;
			hold(4);
			scl = 1'b1;
			hold(6);
		end
		sda_drv = 1'b0;
		hold(6);
	endtask
	task automatic stop();
		scl = 1'b0;
		hold(6);
		sda_drv = 1'b0;
		hold(4);
		scl = 1'b1;
		hold(6);
		sda_drv = 1'b1;
		hold(6);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(ai, a);
	endtask
endmodule

/* test/test_rtcsf_top.sv */
// Self-checking bench for the time, date and supply-flag block
`timescale 1ns/1ps
`include "rtcsf_consts.svh"
`define CHECK_EQ(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e); end end
module test_rtcsf_top;
	localparam logic [7:0] AW = {`RTCSF_DEV_ADDR, 1'b0};
	int err_total = 0;
	int num_checks = 0;
	int carry_seen = 0;
	logic sys_clk, arst_n, scl, sda_drv, sda_wire, sda_oe, sda_out;
	logic osc_stopped, vdd_below_bat, vdd_below_thr, bat_below_low, bat_replaced;
	logic on_backup, month_carry, primary_irq_out_n;
	logic [7:0] month_bcd, year_bcd;
	logic [39:0] r;
	assign sda_wire = sda_drv & ~sda_oe;
	rtcsf_i2c_host host (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
	rtcsf_top #(.TICK_CYCLES(400), .DEV_ADDR(`RTCSF_DEV_ADDR)) dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe(sda_oe), .osc_stopped(osc_stopped), .vdd_below_bat(vdd_below_bat),
		.vdd_below_thr(vdd_below_thr), .bat_below_low(bat_below_low),
		.bat_replaced(bat_replaced), .month_bcd(month_bcd), .year_bcd(year_bcd),
		.on_backup(on_backup), .month_carry(month_carry), .primary_irq_out_n(primary_irq_out_n));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) if (month_carry === 1'b1) carry_seen++;
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] p, input logic [39:0] d, input int n);
		logic [7:0] q;
		logic a;
		host.start(1'b0);
		host.xfer(AW, 1'b1, q, a);
		`CHECK_EQ(a, 1'b0)
		host.xfer(p, 1'b1, q, a);
		for (int i = n - 1; i >= 0; i--) host.xfer(d[8*i +: 8], 1'b1, q, a);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] p, input int n);
		logic [7:0] q;
		logic a;
		host.start(1'b0);
		host.xfer(AW, 1'b1, q, a);
		host.xfer(p, 1'b1, q, a);
		host.start(1'b1);
		host.xfer(AW | 8'h01, 1'b1, q, a);
		`CHECK_EQ(a, 1'b0)
		r = '0;
		for (int i = 0; i < n; i++) begin
			host.xfer(8'hFF, i == n - 1, q, a);
			r = {r[31:0], q};
		end
		host.stop();
	endtask
	// One or two ticks pass; only seconds may differ
	task automatic run_ticks(input logic [39:0] t, input logic [7:0] mon, input logic [7:0] yr);
		month_bcd = mon;
		year_bcd = yr;
		wr(`RTCSF_ADDR_SECONDS, t, 5);
		carry_seen = 0;
		osc_stopped = 1'b0;
		cyc(600);
		osc_stopped = 1'b1;
		cyc(10);
		rd(`RTCSF_ADDR_SECONDS, 5);
		`CHECK_EQ(r[39:33], 7'h40)
	endtask
	task automatic t_osc();
		rd(`RTCSF_ADDR_SECONDS, 1);
		`CHECK_EQ(r[7], 1'b1)
		wr(`RTCSF_ADDR_SECONDS, 40'h00, 1);
		rd(`RTCSF_ADDR_SECONDS, 1);
		`CHECK_EQ(r[7:0], 8'h80)
		osc_stopped = 1'b0;
		cyc(20);
		wr(`RTCSF_ADDR_SECONDS, 40'h00, 1);
		rd(`RTCSF_ADDR_SECONDS, 1);
		`CHECK_EQ(r[7], 1'b0)
		osc_stopped = 1'b1;
		cyc(20);
		osc_stopped = 1'b0;
		cyc(20);
		rd(`RTCSF_ADDR_SECONDS, 1);
		`CHECK_EQ(r[7], 1'b1)
		osc_stopped = 1'b1;
		$display("osc flag test done");
	endtask
	task automatic t_bus();
		logic [7:0] q;
		logic a;
		host.start(1'b0);
		host.xfer(AW ^ 8'h02, 1'b1, q, a);
		`CHECK_EQ(a, 1'b1)
		host.stop();
		wr(8'h20, 40'h5A, 1);
		rd(8'h20, 1);
		`CHECK_EQ(r[7:0], 8'h00)
		wr(`RTCSF_ADDR_WEEKDAYS, 40'h05, 1);
		rd(`RTCSF_ADDR_WEEKDAYS, 1);
		`CHECK_EQ(r[7:0], 8'h05)
		$display("bus test done");
	endtask
	task automatic t_time();
		wr(`RTCSF_ADDR_CTRL_A, 40'h00, 1);
		run_ticks(40'h59_59_23_28_06, 8'h02, 8'h23);
		`CHECK_EQ(r[31:0], 32'h00_00_01_00)
		`CHECK_EQ(carry_seen, 1)
		for (int i = 0; i < 2; i++) begin
			run_ticks(40'h59_59_23_28_03, 8'h02, i ? 8'h00 : 8'h24);
			`CHECK_EQ(r[31:0], 32'h00_00_29_04)
			`CHECK_EQ(carry_seen, 0)
		end
		wr(`RTCSF_ADDR_CTRL_A, 40'h08, 1);
		run_ticks(40'h59_59_11_15_02, 8'h05, 8'h23);
		`CHECK_EQ(r[31:0], 32'h00_32_15_02)
		run_ticks(40'h59_59_31_15_02, 8'h05, 8'h23);
		`CHECK_EQ(r[31:0], 32'h00_12_16_03)
		wr(`RTCSF_ADDR_CTRL_A, 40'h00, 1);
		$display("time test done");
	endtask
	task automatic t_supply();
		logic [2:0] pm;
		logic sw;
		wr(`RTCSF_ADDR_CTRL_B, 40'h02, 1);
		for (int i = 0; i < 8; i++) begin
			if (i == 6) continue;
			pm = 3'(i);
			sw = (pm[1:0] < 2'h2);
			wr(`RTCSF_ADDR_CTRL_C, {32'h0, pm, 5'h00}, 1);
			vdd_below_bat = 1'b1;
			cyc(20);
			`CHECK_EQ(on_backup, pm[1:0] == 2'h1)
			vdd_below_thr = 1'b1;
			cyc(20);
			`CHECK_EQ(on_backup, sw)
			`CHECK_EQ(primary_irq_out_n, ~sw)
			vdd_below_bat = 1'b0;
			vdd_below_thr = 1'b0;
			cyc(20);
			rd(`RTCSF_ADDR_CTRL_C, 1);
			`CHECK_EQ({r[7:5], r[3]}, {pm, sw})
			wr(`RTCSF_ADDR_CTRL_C, {32'h0, pm, 5'h00}, 1);
			`CHECK_EQ(primary_irq_out_n, 1'b1)
		end
		wr(`RTCSF_ADDR_CTRL_C, 40'hC0, 1);
		rd(`RTCSF_ADDR_CTRL_C, 1);
		`CHECK_EQ(r[7:5], 3'h7)
		wr(`RTCSF_ADDR_CTRL_B, 40'h00, 1);
		$display("supply test done");
	endtask
	task automatic t_cell();
		wr(`RTCSF_ADDR_CTRL_C, 40'h20, 1);
		wr(`RTCSF_ADDR_CTRL_B, 40'h01, 1);
		vdd_below_bat = 1'b1;
		cyc(20);
		bat_below_low = 1'b1;
		cyc(20);
		`CHECK_EQ(primary_irq_out_n, 1'b0)
		vdd_below_bat = 1'b0;
		bat_below_low = 1'b0;
		cyc(20);
		wr(`RTCSF_ADDR_CTRL_C, 40'h20, 1);
		rd(`RTCSF_ADDR_CTRL_C, 1);
		`CHECK_EQ(r[3:2], 2'b01)
		`CHECK_EQ(primary_irq_out_n, 1'b0)
		wr(`RTCSF_ADDR_CTRL_B, 40'h00, 1);
		`CHECK_EQ(primary_irq_out_n, 1'b1)
		wr(`RTCSF_ADDR_CTRL_B, 40'h01, 1);
		`CHECK_EQ(primary_irq_out_n, 1'b0)
		bat_replaced = 1'b1;
		cyc(20);
		bat_replaced = 1'b0;
		cyc(5);
		`CHECK_EQ(primary_irq_out_n, 1'b1)
		wr(`RTCSF_ADDR_CTRL_C, 40'hE0, 1);
		$display("cell low test done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		arst_n = 1'b0;
		osc_stopped = 1'b1;
		vdd_below_bat = 1'b0;
		vdd_below_thr = 1'b0;
		bat_below_low = 1'b0;
		bat_replaced = 1'b0;
		month_bcd = 8'h01;
		year_bcd = 8'h00;
		cyc(2);
		arst_n = 1'b1;
		cyc(10);
		t_osc();
		t_bus();
		t_time();
		t_supply();
		t_cell();
		end_sim();
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		err_total++;
		end_sim();
	end
endmodule
